//--- src/shswc_top.sv
// Standby controller: stop-release wait select, stabilisation status, halt gating
//
// How it works
// - Software-writable selection sets high-speed oscillator wait after stop release.
// - Wait holds the CPU only when it runs on high-speed clock.
// - Selection register takes whole-byte writes only; bit writes are ignored.
// - Reset loads selection with 05h, the longest wait.
// - Codes 1..5 give 2^11,2^13,2^14,2^15,2^16 periods; others prohibited.
// - Counter runs only for the selected wait; status shows at most that.
// - Counting starts when oscillation starts, not at stop release.
// - Halt instruction enters halt from either CPU clock.
// - Halt gates the CPU clock; oscillators keep their state.
// - Port output latches hold their values during halt.
// - Halt from high-speed runs all timers, the watchdog only if ring is not stoppable; from ring only listed sources.
`timescale 1ns/1ps
`default_nettype none

module shswc_top (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic SRST_I,
    // CPU memory access
    input wire shswc_pkg::shswc_bus_req_t BUS_REQ_I,
    output logic [7:0] RD_DATA_O,
    // CPU standby instructions and wake
    input wire logic HALT_EXEC_I,
    input wire logic STOP_EXEC_I,
    input wire logic WAKE_I,
    input wire logic CPU_ON_HS_I,
    // Clock generator
    input wire logic HS_OSC_RUN_I,
    input wire logic HS_TICK_I,
    input wire logic RING_STOPPABLE_I,
    output logic HS_OSC_EN_O,
    output logic CPU_CLK_EN_O,
    // Peripheral control
    input wire shswc_pkg::shswc_timer_src_t TIMER_SRC_I,
    output shswc_pkg::shswc_timer_en_t TIMER_EN_O,
    output logic PORT_HOLD_O,
    output logic RETAIN_O,
    output logic STANDBY_O
);
    import shswc_pkg::*;

    typedef struct packed {
        shswc_state_t st;
        logic [2:0] wait_sel;
        logic hs_at_entry;
        logic osc_wait;
        logic stab_run;
        logic cnt_clear;
        logic osc_meta;
        logic osc_sync;
        logic [7:0] rd_data;
        logic hs_osc_en;
        logic cpu_clk_en;
        shswc_timer_en_t tmr_en;
        logic port_hold;
        logic retain;
    } shswc_top_state_t;

    shswc_top_state_t s_q;
    shswc_top_state_t s_d;
    logic [SHSWC_STAT_W-1:0] stat;
    logic cnt_done;
    logic sel_wr;
    logic standby_d;

    // ==========================================================
    // Stabilisation counter
    shswc_stab_cnt u_cnt (
        .clk_i(REF_CLK_I),
        .srst_i(SRST_I),
        .clear_i(s_q.cnt_clear),
        .run_i(s_q.stab_run),
        .tick_i(HS_TICK_I),
        .code_i(s_q.wait_sel),
        .status_o(stat),
        .done_o(cnt_done)
    );

    // ==========================================================
    // Register access
    // byte writes only
    assign sel_wr = BUS_REQ_I.wr && !BUS_REQ_I.bit_wr &&
                    (BUS_REQ_I.addr == SHSWC_WAIT_SEL_ADDR);

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.cnt_clear = 1'b0;
        standby_d = 1'b0;
        // Oscillator start is an analogue event; two flops before use
        s_d.osc_meta = HS_OSC_RUN_I;
        s_d.osc_sync = s_q.osc_meta;

        if (sel_wr) begin
            s_d.wait_sel = BUS_REQ_I.wdata[2:0];
        end

        s_d.rd_data = SHSWC_RD_NONE;
        if (BUS_REQ_I.rd) begin
            if (BUS_REQ_I.addr == SHSWC_WAIT_SEL_ADDR) begin
                s_d.rd_data = {5'h00, s_q.wait_sel};
            end else if (BUS_REQ_I.addr == SHSWC_STATUS_ADDR) begin
                s_d.rd_data = {3'h0, stat};
            end
        end

        if (s_q.osc_wait && s_q.osc_sync) begin
            s_d.osc_wait = 1'b0;
            s_d.stab_run = 1'b1;
        end
        if (s_q.stab_run && cnt_done) begin
            s_d.stab_run = 1'b0;
        end

        case (s_q.st)
            SHSWC_RUN: begin
                if (STOP_EXEC_I) begin
                    s_d.st = SHSWC_STOP;
                    s_d.hs_at_entry = CPU_ON_HS_I;
                    s_d.cnt_clear = 1'b1;
                    s_d.osc_wait = 1'b0;
                    s_d.stab_run = 1'b0;
                end else if (HALT_EXEC_I) begin
                    s_d.st = SHSWC_HALT;
                    s_d.hs_at_entry = CPU_ON_HS_I;
                end
            end
            SHSWC_HALT: begin
                if (WAKE_I) begin
                    s_d.st = SHSWC_RUN;
                end
            end
            SHSWC_STOP: begin
                if (WAKE_I) begin
                    s_d.osc_wait = 1'b1;
                    // hold CPU only on high-speed clock
                    if (s_q.hs_at_entry) begin
                        s_d.st = SHSWC_STOP_WAIT;
                    end else begin
                        s_d.st = SHSWC_RUN;
                    end
                end
            end
            SHSWC_STOP_WAIT: begin
                if (s_q.stab_run && cnt_done) begin
                    s_d.st = SHSWC_RUN;
                end
            end
            default: begin
                s_d.st = SHSWC_RUN;
            end
        endcase

        // Outputs follow the next state so each leaves a flop
        standby_d = (s_d.st != SHSWC_RUN);
        s_d.hs_osc_en = (s_d.st != SHSWC_STOP);
        s_d.cpu_clk_en = !standby_d;
        s_d.port_hold = standby_d;
        s_d.retain = standby_d;

        s_d.tmr_en = '{tmr16_en: 1'b1, evt_en: 1'b1, h0_en: 1'b1, h1_en: 1'b1,
                       wdt_en: 1'b1};
        if (s_d.st == SHSWC_HALT && !s_d.hs_at_entry) begin
            // only guaranteed sources on ring clock
            s_d.tmr_en.tmr16_en = 1'b0;
            s_d.tmr_en.evt_en = TIMER_SRC_I.evt_src_ext;
            s_d.tmr_en.h0_en = TIMER_SRC_I.h0_src_evt;
            s_d.tmr_en.h1_en = TIMER_SRC_I.h1_src_rdiv;
        end else if (s_d.st == SHSWC_STOP || s_d.st == SHSWC_STOP_WAIT) begin
            // Peripherals other than the watchdog have no clock in stop and in the stop-release wait
            s_d.tmr_en.tmr16_en = 1'b0;
            s_d.tmr_en.evt_en = 1'b0;
            s_d.tmr_en.h0_en = 1'b0;
            s_d.tmr_en.h1_en = 1'b0;
        end
        if (standby_d) begin
            s_d.tmr_en.wdt_en = !RING_STOPPABLE_I;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            s_q <= '0;
            s_q.st <= SHSWC_RUN;
            s_q.wait_sel <= SHSWC_WAIT_SEL_RST;
            s_q.hs_osc_en <= 1'b1;
            s_q.cpu_clk_en <= 1'b1;
            s_q.tmr_en <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign RD_DATA_O = s_q.rd_data;
    assign HS_OSC_EN_O = s_q.hs_osc_en;
    assign CPU_CLK_EN_O = s_q.cpu_clk_en;
    assign TIMER_EN_O = s_q.tmr_en;
    assign PORT_HOLD_O = s_q.port_hold;
    assign RETAIN_O = s_q.retain;
    assign STANDBY_O = s_q.retain;

endmodule
`default_nettype wire

//--- src/shswc_pkg.sv
// Shared constants and types for the standby halt/stop wait controller
package shswc_pkg;

    // ==========================================================
    // Register map
    localparam logic [15:0] SHSWC_STATUS_ADDR = 16'hffa3;
    localparam logic [15:0] SHSWC_WAIT_SEL_ADDR = 16'hffa4;
    localparam logic [2:0] SHSWC_WAIT_SEL_RST = 3'h5;
    localparam logic [7:0] SHSWC_RD_NONE = 8'h00;

    // ==========================================================
    // Wait codes and counter layout
    localparam int SHSWC_CNT_W = 17;
    localparam int SHSWC_STAT_W = 5;
    localparam logic [4:0] SHSWC_EXP_LONGEST = 5'h10;
    // Status bit 4 marks 2^11 periods, bit 0 marks 2^16 periods
    localparam logic [4:0][4:0] SHSWC_STAT_EXP = {5'h0b, 5'h0d, 5'h0e, 5'h0f, 5'h10};

    function automatic logic [4:0] shswc_wait_exp(input logic [2:0] code);
        logic [4:0] e;
        e = SHSWC_EXP_LONGEST;
        case (code)
            3'h1: e = 5'h0b;
            3'h2: e = 5'h0d;
            3'h3: e = 5'h0e;
            3'h4: e = 5'h0f;
            3'h5: e = 5'h10;
            // Prohibited codes fall back to the longest, safest wait
            default: e = SHSWC_EXP_LONGEST;
        endcase
        return e;
    endfunction

    // ==========================================================
    // Power states and carriers
    typedef enum logic [1:0] {
        SHSWC_RUN = 2'b00,
        SHSWC_HALT = 2'b01,
        SHSWC_STOP = 2'b10,
        SHSWC_STOP_WAIT = 2'b11
    } shswc_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic bit_wr;
        logic rd;
        logic [7:0] wdata;
    } shswc_bus_req_t;

    typedef struct packed {
        logic tmr16_en;
        logic evt_en;
        logic h0_en;
        logic h1_en;
        logic wdt_en;
    } shswc_timer_en_t;

    typedef struct packed {
        logic evt_src_ext;
        logic h0_src_evt;
        logic h1_src_rdiv;
    } shswc_timer_src_t;

endpackage

//--- src/shswc_stab_cnt.sv
// Oscillation stabilisation counter with threshold status bits
`timescale 1ns/1ps
`default_nettype none

module shswc_stab_cnt (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Control
    input wire logic clear_i,
    input wire logic run_i,
    input wire logic tick_i,
    input wire logic [2:0] code_i,
    // Status
    output logic [shswc_pkg::SHSWC_STAT_W-1:0] status_o,
    output logic done_o
);
    import shswc_pkg::*;

    typedef struct packed {
        logic [SHSWC_CNT_W-1:0] cnt;
    } shswc_cnt_state_t;

    shswc_cnt_state_t s_q;
    shswc_cnt_state_t s_d;
    logic [SHSWC_CNT_W-1:0] limit;

    // ==========================================================
    // Limit and status
    // code to wait length
    assign limit = SHSWC_CNT_W'(1) << shswc_wait_exp(code_i);
    assign done_o = (s_q.cnt >= limit);

    genvar k;
    generate
        for (k = 0; k < SHSWC_STAT_W; k++) begin : g_stat
            assign status_o[k] = (s_q.cnt >= (SHSWC_CNT_W'(1) << SHSWC_STAT_EXP[k]));
        end
    endgenerate

    // ==========================================================
    // Counter
    always_comb begin
        s_d = s_q;
        if (clear_i) begin
            s_d.cnt = '0;
        end else if (run_i && tick_i && !done_o) begin
            s_d.cnt = s_q.cnt + SHSWC_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule
`default_nettype wire

//--- verification/shswc_props.sv
// Port checker for the standby controller
`timescale 1ns/1ps
`default_nettype none
module shswc_props
    import shswc_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic SRST_I,
    input wire shswc_pkg::shswc_bus_req_t BUS_REQ_I,
    input wire logic [7:0] RD_DATA_O,
    input wire logic HALT_EXEC_I,
    input wire logic STOP_EXEC_I,
    input wire logic WAKE_I,
    input wire logic CPU_ON_HS_I,
    input wire logic RING_STOPPABLE_I,
    input wire logic HS_OSC_EN_O,
    input wire logic CPU_CLK_EN_O,
    input wire shswc_pkg::shswc_timer_src_t TIMER_SRC_I,
    input wire shswc_pkg::shswc_timer_en_t TIMER_EN_O,
    input wire logic PORT_HOLD_O,
    input wire logic RETAIN_O,
    input wire logic STANDBY_O
);
    // =====
    // Properties
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (SRST_I);
    a_halt_gates_cpu: assert property (
        HALT_EXEC_I && !STOP_EXEC_I && CPU_CLK_EN_O |=> !CPU_CLK_EN_O && HS_OSC_EN_O)
        else $error("halt did not gate the cpu clock");
    a_standby_holds: assert property (
        !CPU_CLK_EN_O |-> PORT_HOLD_O && RETAIN_O && STANDBY_O)
        else $error("hold outputs low in standby");
    a_hs_halt_timers: assert property (
        HALT_EXEC_I && !STOP_EXEC_I && CPU_CLK_EN_O && CPU_ON_HS_I
        |=> TIMER_EN_O == {4'hf, ~RING_STOPPABLE_I})
        else $error("timer enables wrong in halt on fast clock");
    a_ring_halt_timers: assert property (
        HALT_EXEC_I && !STOP_EXEC_I && CPU_CLK_EN_O && !CPU_ON_HS_I
        |=> TIMER_EN_O == {1'b0, TIMER_SRC_I, ~RING_STOPPABLE_I})
        else $error("timer enables wrong in halt on ring clock");
    a_stop_osc_off: assert property (
        !HS_OSC_EN_O && !WAKE_I |=> !HS_OSC_EN_O)
        else $error("oscillator enabled without wake");
    a_hs_wait_held: assert property (
        !HS_OSC_EN_O && WAKE_I && CPU_ON_HS_I |=> !CPU_CLK_EN_O [*8])
        else $error("cpu clock back before the wait");
    a_ring_wake_fast: assert property (
        !HS_OSC_EN_O && WAKE_I && !CPU_ON_HS_I |=> CPU_CLK_EN_O)
        else $error("ring clock wake was delayed");
    a_rd_idle_zero: assert property (
        !BUS_REQ_I.rd |=> RD_DATA_O == 8'h00)
        else $error("read data not zero when idle");
    a_sel_upper_zero: assert property (
        BUS_REQ_I.rd && BUS_REQ_I.addr == SHSWC_WAIT_SEL_ADDR |=> RD_DATA_O[7:3] == 5'h00)
        else $error("select register upper bits set");
endmodule
bind shswc_top shswc_props i_props (.REF_CLK_I, .SRST_I, .BUS_REQ_I, .RD_DATA_O, .HALT_EXEC_I,
    .STOP_EXEC_I, .WAKE_I, .CPU_ON_HS_I, .RING_STOPPABLE_I, .HS_OSC_EN_O, .CPU_CLK_EN_O,
    .TIMER_SRC_I, .TIMER_EN_O, .PORT_HOLD_O, .RETAIN_O, .STANDBY_O);
`default_nettype wire

//--- verification/shswc_top_test.sv
// Self-checking bench for the standby controller
`timescale 1ns/1ps
`default_nettype none
module shswc_top_test;
    import shswc_pkg::*;
    typedef struct packed {
        logic w; logic b; logic [15:0] a; logic [7:0] d; logic [15:0] ra; logic [7:0] e;
    } shswc_row_t;
    logic clk = 1'b0;
    logic srst = 1'b1;
    shswc_bus_req_t req = '0;
    logic halt = 1'b0, stop = 1'b0, wake = 1'b0, on_hs = 1'b1;
    logic osc_run = 1'b1, tick = 1'b1, ring_stop = 1'b0;
    shswc_timer_src_t src = '0;
    logic [7:0] rd;
    logic osc_en, cpu_en, hold, retain, stby;
    shswc_timer_en_t ten;
    int fails = 0, num_checks = 0, n;
    // Ticks every cycle keep the 2^11 wait short
    shswc_row_t t [8] = '{
        {2'b10, 16'hffa4, 8'h01, 16'hffa4, 8'h01}, {2'b10, 16'hffa4, 8'h02, 16'hffa4, 8'h02},
        {2'b10, 16'hffa4, 8'h03, 16'hffa4, 8'h03}, {2'b10, 16'hffa4, 8'h04, 16'hffa4, 8'h04},
        {2'b10, 16'hffa4, 8'h05, 16'hffa4, 8'h05}, {2'b11, 16'hffa4, 8'h02, 16'hffa4, 8'h05},
        {2'b10, 16'hffa3, 8'h1f, 16'hffa3, 8'h00}, {2'b00, 16'h0000, 8'h00, 16'hffa5, 8'h00}};
    shswc_top i_dut (.REF_CLK_I(clk), .SRST_I(srst), .BUS_REQ_I(req), .RD_DATA_O(rd),
        .HALT_EXEC_I(halt), .STOP_EXEC_I(stop), .WAKE_I(wake), .CPU_ON_HS_I(on_hs),
        .HS_OSC_RUN_I(osc_run), .HS_TICK_I(tick), .RING_STOPPABLE_I(ring_stop),
        .HS_OSC_EN_O(osc_en), .CPU_CLK_EN_O(cpu_en), .TIMER_SRC_I(src), .TIMER_EN_O(ten),
        .PORT_HOLD_O(hold), .RETAIN_O(retain), .STANDBY_O(stby));
    initial begin
        forever #4 clk = ~clk;
    end
    // =====
    // Tasks
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk8(nm, {7'h00, e}, {7'h00, g});
    endtask
    task automatic cyc(input logic w, b, input logic [15:0] a, input logic [7:0] d, input logic r);
        @(negedge clk);
        req = '{addr: a, wr: w, bit_wr: b, rd: r, wdata: d};
        @(negedge clk);
        req = '0;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        cyc(1'b0, 1'b0, a, 8'h00, 1'b1);
        chk8("rd_data", e, rd);
    endtask
    task automatic pulse(input logic [2:0] k);
        @(negedge clk);
        {halt, stop, wake} = k;
        @(negedge clk);
        {halt, stop, wake} = 3'b000;
    endtask
    task automatic stop_run(input logic hs);
        on_hs = hs;
        pulse(3'b010);
        osc_run = 1'b0;
        chk1("osc_en", 1'b0, osc_en);
        rdchk(SHSWC_STATUS_ADDR, 8'h00);
        pulse(3'b001);
        chk1("cpu_en", ~hs, cpu_en);
        repeat (100) @(negedge clk);
        chk1("cpu_en", ~hs, cpu_en);
        osc_run = 1'b1;
        n = 0;
        while (cpu_en !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (hs) chk1("wait_len", 1'b1, 1'(n >= 2048 && n <= 2056));
        // Run past 2^13 ticks so a counter that overran its wait would show bit 3
        else repeat (8300) @(negedge clk);
        rdchk(SHSWC_STATUS_ADDR, 8'h10);
        $display("stop test hs=%0d done", hs);
    endtask
    task automatic end_sim();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // =====
    // Sequence
    initial begin
        #(8 * 50000);
        fails++;
        end_sim();
    end
    initial begin
        repeat (10) @(negedge clk);
        srst = 1'b0;
        foreach (t[i]) begin
            cyc(t[i].w, t[i].b, t[i].a, t[i].d, 1'b0);
            rdchk(t[i].ra, t[i].e);
        end
        // Read in the write cycle must see the old value
        cyc(1'b1, 1'b0, SHSWC_WAIT_SEL_ADDR, 8'h03, 1'b1);
        chk8("rd_old", 8'h05, rd);
        @(negedge clk);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk8("reset_outs", 8'hdf, {cpu_en, osc_en, 1'b0, ten});
        chk1("reset_hold", 1'b0, hold | retain | stby);
        rdchk(SHSWC_WAIT_SEL_ADDR, 8'h05);
        $display("register and reset tests done");
        src = 3'b101;
        for (int i = 0; i < 2; i++) begin
            on_hs = (i == 0);
            ring_stop = (i == 1);
            pulse(3'b100);
            chk1("halt_cpu", 1'b0, cpu_en);
            chk1("halt_osc", 1'b1, osc_en);
            chk1("halt_hold", 1'b1, hold & retain & stby);
            chk8("halt_tmr", (i == 0) ? 8'h1f : 8'h0a, {3'h0, ten});
            pulse(3'b010);
            chk1("halt_stop", 1'b1, osc_en);
            pulse(3'b001);
            chk1("halt_wake", 1'b1, cpu_en);
            $display("halt test %0d done", i);
        end
        cyc(1'b1, 1'b0, SHSWC_WAIT_SEL_ADDR, 8'h01, 1'b0);
        stop_run(1'b1);
        stop_run(1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
